// >>> core/noload_pkg.sv
// constants and types shared by the no-load detection block
// Overview of operation
// - active and apparent both idle blocks total active
// - fundamental active and reactive idle blocks both
// - total no-load in status bit 0, phase bits 2:0
// - fundamental no-load in status bit 1, bits 5:3
// - apparent crossing either way sets status bit 2
// - flag with mask bit 2 drives interrupt low
// - apparent crossing toggles that phase's field bit
// - writing one clears flag, interrupt returns high, unless a crossing lands in that cycle
// - term select gates each phase's pulse contribution
// - read-reset enable clears energy register after read
package noload_pkg;
    localparam int NUM_PHASES = 3;
    localparam int ENERGY_W = 32;
    localparam int THRESH_W = 16;
    localparam int NUM_KINDS = 4;
    // threshold unit and the clock it is counted on
    localparam int TICK_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 5;
    // first status register bits
    localparam int STAT_TOTAL_BIT = 0;
    localparam int STAT_FUND_BIT = 1;
    localparam int STAT_APP_BIT = 2;
    localparam int STAT_W = 3;
    // first interrupt mask bit for the apparent flag
    localparam int MASK_APP_BIT = 2;
    localparam int MASK_W = 8;
    // phase no-load register fields
    localparam int PH_TOTAL_LSB = 0;
    localparam int PH_FUND_LSB = 3;
    localparam int PH_APP_LSB = 6;
    localparam int PH_W = 9;
    // line-cycle mode register read-reset bit
    localparam int LCYC_READ_RESET_ENABLE_BIT = 6;
    localparam int LCYC_W = 8;
    // identity value, arbitrary
    localparam logic [7:0] DIE_VERSION = 8'h5A;

    // energy kinds, also the read selector
    typedef enum logic [1:0] {KIND_ACT, KIND_APP, KIND_FACT, KIND_FREACT} kind_e;

    // one quantum of each energy kind for one phase
    typedef struct packed {
        logic freact;
        logic fact;
        logic app;
        logic act;
    } energy_evt_s;

    // energy register read request
    typedef struct packed {
        logic valid;
        logic [1:0] phase;
        kind_e kind;
    } energy_rd_s;
endpackage : noload_pkg

// >>> core/noload_timer.sv
// per-phase idle timer for one energy kind
`timescale 1ns/10ps
module noload_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic accum,
    input wire logic [noload_pkg::THRESH_W-1:0] threshold,
    output logic idle
);
    // time units since the last accumulation, saturating
    logic [noload_pkg::THRESH_W-1:0] count;
    wire at_max = &count;

    // restart on accumulation, else count units
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (accum) begin
            count <= '0;
        end else if (tick && !at_max) begin
            count <= count + 1'b1;
        end
    end

    // a zero threshold is always expired, so that check drops out
    assign idle = (count >= threshold);
endmodule : noload_timer

// >>> core/energy_accum.sv
// one energy register with blocking and read-reset clear
`timescale 1ns/10ps
module energy_accum (
    input wire logic clk,
    input wire logic rstn,
    input wire logic add,
    input wire logic block,
    input wire logic clear,
    output logic [noload_pkg::ENERGY_W-1:0] value
);
    wire take = add && !block;

    // a quantum arriving with the clear is kept, not lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            value <= '0;
        end else if (clear) begin
            value <= take ? {{(noload_pkg::ENERGY_W-1){1'b0}}, 1'b1} : '0;
        end else if (take) begin
            value <= value + 1'b1;
        end
    end
endmodule : energy_accum

// >>> core/energy_no_load_detect.sv
// no-load detection, energy blocking and apparent no-load interrupt
`timescale 1ns/10ps
module energy_no_load_detect (
    input wire logic clk,
    input wire logic rstn,
    // energy quanta from the signal path, one struct per phase
    input wire noload_pkg::energy_evt_s [noload_pkg::NUM_PHASES-1:0] energy_evt,
    input wire logic [noload_pkg::THRESH_W-1:0] active_noload_threshold,
    input wire logic [noload_pkg::THRESH_W-1:0] apparent_noload_threshold,
    input wire logic [noload_pkg::THRESH_W-1:0] reactive_noload_threshold,
    input wire logic [noload_pkg::NUM_PHASES-1:0] phase_term_select,
    input wire logic [noload_pkg::MASK_W-1:0] first_interrupt_mask,
    input wire logic [noload_pkg::LCYC_W-1:0] line_cycle_mode_register,
    // write-one-to-clear strobe onto the first status register
    input wire logic [noload_pkg::STAT_W-1:0] status_w1c,
    input wire noload_pkg::energy_rd_s energy_rd,
    output logic [noload_pkg::ENERGY_W-1:0] energy_rd_data,
    output logic energy_rd_valid,
    output logic [noload_pkg::STAT_W-1:0] first_status_register,
    output logic [noload_pkg::PH_W-1:0] phase_noload_register,
    output logic [noload_pkg::NUM_KINDS-1:0] energy_pulse_output,
    output logic [7:0] die_version,
    output logic irq_n
);
    localparam int NP = noload_pkg::NUM_PHASES;
    localparam int NK = noload_pkg::NUM_KINDS;
    localparam int TC = noload_pkg::TICK_CYCLES;

    // true when a read selects this phase and kind
    function automatic logic rd_hit(input noload_pkg::energy_rd_s rd, input int p, input int k);
        rd_hit = rd.valid && (int'(rd.phase) == p) && (int'(rd.kind) == k);
    endfunction : rd_hit

    // threshold unit prescaler
    logic [noload_pkg::TICK_W-1:0] tick_cnt;
    wire tick = (tick_cnt == noload_pkg::TICK_W'(TC - 1));

    // idle state per phase per kind
    logic [NP-1:0] act_idle;
    logic [NP-1:0] app_idle;
    logic [NP-1:0] fact_idle;
    logic [NP-1:0] freact_idle;
    // combined no-load states
    wire [NP-1:0] nl_total = act_idle & app_idle;
    wire [NP-1:0] nl_fund = fact_idle & freact_idle;
    // apparent idle as seen last cycle, for crossing detection
    logic [NP-1:0] app_idle_q;
    wire [NP-1:0] app_trans = app_idle ^ app_idle_q;
    // toggled once per apparent crossing
    logic [NP-1:0] app_phase_bits;
    logic app_flag;
    logic [NP-1:0] total_ph;
    logic [NP-1:0] fund_ph;
    // the energy registers themselves
    logic [noload_pkg::ENERGY_W-1:0] acc_val [NP][NK];
    wire read_reset_enable = line_cycle_mode_register[noload_pkg::LCYC_READ_RESET_ENABLE_BIT];

    // unit tick generation
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
        end
    end

    // per-phase timers and energy registers
    genvar p;
    genvar k;
    generate
        for (p = 0; p < NP; p++) begin : g_phase
            // fundamental active shares the active threshold
            noload_timer u_act (.clk(clk), .rstn(rstn), .tick(tick), .accum(energy_evt[p].act),
                .threshold(active_noload_threshold), .idle(act_idle[p]));
            noload_timer u_app (.clk(clk), .rstn(rstn), .tick(tick), .accum(energy_evt[p].app),
                .threshold(apparent_noload_threshold), .idle(app_idle[p]));
            noload_timer u_fact (.clk(clk), .rstn(rstn), .tick(tick), .accum(energy_evt[p].fact),
                .threshold(active_noload_threshold), .idle(fact_idle[p]));
            noload_timer u_freact (.clk(clk), .rstn(rstn), .tick(tick), .accum(energy_evt[p].freact),
                .threshold(reactive_noload_threshold), .idle(freact_idle[p]));
            for (k = 0; k < NK; k++) begin : g_kind
                // apparent is never blocked; fundamental pair blocks together
                wire add = energy_evt[p][k];
                wire blk = (k == int'(noload_pkg::KIND_ACT)) ? nl_total[p] :
                           (k == int'(noload_pkg::KIND_APP)) ? 1'b0 : nl_fund[p];
                wire clr = read_reset_enable && rd_hit(energy_rd, p, k);
                energy_accum u_acc (.clk(clk), .rstn(rstn), .add(add), .block(blk), .clear(clr),
                    .value(acc_val[p][k]));
            end
        end
    endgenerate

    // pulse contributions per kind, gated by term select and, except apparent, no-load
    wire [NP-1:0] act_c;
    wire [NP-1:0] app_c;
    wire [NP-1:0] fact_c;
    wire [NP-1:0] freact_c;
    generate
        for (p = 0; p < NP; p++) begin : g_pulse
            assign act_c[p] = energy_evt[p].act && !nl_total[p] && phase_term_select[p];
            assign app_c[p] = energy_evt[p].app && phase_term_select[p];
            assign fact_c[p] = energy_evt[p].fact && !nl_fund[p] && phase_term_select[p];
            assign freact_c[p] = energy_evt[p].freact && !nl_fund[p] && phase_term_select[p];
        end
    endgenerate
    wire [NK-1:0] next_pulse = {|freact_c, |fact_c, |app_c, |act_c};

    // energy pulse outputs, registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            energy_pulse_output <= '0;
        end else begin
            energy_pulse_output <= next_pulse;
        end
    end

    // apparent crossing tracking
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            app_idle_q <= '0;
            app_phase_bits <= '0;
        end else begin
            app_idle_q <= app_idle;
            app_phase_bits <= app_phase_bits ^ app_trans;
        end
    end

    // sticky apparent flag; a crossing in the clearing cycle wins
    wire app_clr = status_w1c[noload_pkg::STAT_APP_BIT];
    wire next_app_flag = (|app_trans) ? 1'b1 : (app_clr ? 1'b0 : app_flag);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            app_flag <= 1'b0;
        end else begin
            app_flag <= next_app_flag;
        end
    end

    // live no-load levels per phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            total_ph <= '0;
            fund_ph <= '0;
        end else begin
            total_ph <= nl_total;
            fund_ph <= nl_fund;
        end
    end

    // status and phase register views
    assign first_status_register = {app_flag, |fund_ph, |total_ph};
    assign phase_noload_register = {app_phase_bits, fund_ph, total_ph};
    // low while the masked flag stands
    assign irq_n = !(app_flag && first_interrupt_mask[noload_pkg::MASK_APP_BIT]);
    assign die_version = noload_pkg::DIE_VERSION;

    // energy register read port; captures before the clear lands
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            energy_rd_data <= '0;
            energy_rd_valid <= 1'b0;
        end else begin
            energy_rd_valid <= energy_rd.valid;
            if (energy_rd.valid) begin
                energy_rd_data <= acc_val[energy_rd.phase][energy_rd.kind];
            end
        end
    end

    // checks next to the logic
    property p_flag_on_cross;
        @(posedge clk) disable iff (!rstn) (|app_trans) |=> first_status_register[2];
    endproperty
    a_flag_on_cross: assert property (p_flag_on_cross) else $error("apparent flag missed a crossing");

    property p_irq_low;
        @(posedge clk) disable iff (!rstn)
            ((|app_trans) && first_interrupt_mask[2]) |=> !irq_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt not asserted on crossing");

    property p_clear_flag;
        @(posedge clk) disable iff (!rstn) (status_w1c[2] && !(|app_trans)) |=> (irq_n && !app_flag);
    endproperty
    a_clear_flag: assert property (p_clear_flag) else $error("flag clear did not release interrupt");

    property p_toggle;
        @(posedge clk) disable iff (!rstn)
            (|app_trans) |=> (phase_noload_register[8:6] == ($past(phase_noload_register[8:6]) ^ $past(app_trans)));
    endproperty
    a_toggle: assert property (p_toggle) else $error("phase field did not toggle");

    // a read that hits the register may clear it, so that cycle is left out
    property p_total_block;
        @(posedge clk) disable iff (!rstn)
            (nl_total[1] && !rd_hit(energy_rd, 1, 0)) |=> $stable(acc_val[1][0]);
    endproperty
    a_total_block: assert property (p_total_block) else $error("active energy grew in no-load");

    property p_fund_pulse;
        @(posedge clk) disable iff (!rstn) (&nl_fund) |=> (energy_pulse_output[3:2] == 2'h0);
    endproperty
    a_fund_pulse: assert property (p_fund_pulse) else $error("fundamental pulse in no-load");

    property p_term_sel;
        @(posedge clk) disable iff (!rstn) (phase_term_select == 3'h0) |=> (energy_pulse_output == 4'h0);
    endproperty
    a_term_sel: assert property (p_term_sel) else $error("pulse with all phases deselected");

    property p_read_reset;
        @(posedge clk) disable iff (!rstn)
            (energy_rd.valid && read_reset_enable && !energy_evt[energy_rd.phase][energy_rd.kind])
            |=> (acc_val[$past(energy_rd.phase)][$past(energy_rd.kind)] == 32'h0);
    endproperty
    a_read_reset: assert property (p_read_reset) else $error("energy not cleared by read");

    property p_status_levels;
        @(posedge clk) disable iff (!rstn)
            rstn |=> ((phase_noload_register[5:0] == {$past(nl_fund), $past(nl_total)})
                && (first_status_register[1:0] == {|$past(nl_fund), |$past(nl_total)}));
    endproperty
    a_status_levels: assert property (p_status_levels) else $error("status bits disagree with phases");

    property p_timer_restart;
        @(posedge clk) disable iff (!rstn)
            (energy_evt[0].app && apparent_noload_threshold > 16'h0001) |=> ##0 !app_idle[0] [*2];
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

    // a blocked phase must not leak into the active pulse
    property p_act_block;
        @(posedge clk) disable iff (!rstn)
            (nl_total[1] && energy_evt[1].act && !energy_evt[0].act && !energy_evt[2].act) |=> !energy_pulse_output[0];
    endproperty
    a_act_block: assert property (p_act_block) else $error("active pulse from blocked phase");

    // apparent energy is never blocked, only deselected
    property p_app_pulse;
        @(posedge clk) disable iff (!rstn)
            (rstn && energy_evt[0].app && phase_term_select[0]) |=> energy_pulse_output[1];
    endproperty
    a_app_pulse: assert property (p_app_pulse) else $error("apparent pulse missing");

    // a selected live phase reaches the active pulse
    property p_act_pulse;
        @(posedge clk) disable iff (!rstn)
            (rstn && energy_evt[0].act && !nl_total[0] && phase_term_select[0]) |=> energy_pulse_output[0];
    endproperty
    a_act_pulse: assert property (p_act_pulse) else $error("active pulse missing");

    // fundamental pair frozen together in fundamental no-load
    property p_fund_block;
        @(posedge clk) disable iff (!rstn)
            (nl_fund[0] && !rd_hit(energy_rd, 0, 2) && !rd_hit(energy_rd, 0, 3))
            |=> ($stable(acc_val[0][2]) && $stable(acc_val[0][3]));
    endproperty
    a_fund_block: assert property (p_fund_block) else $error("fundamental energy grew in no-load");

    // a live phase counts every quantum
    property p_act_accum;
        @(posedge clk) disable iff (!rstn)
            (rstn && energy_evt[0].act && !nl_total[0] && !rd_hit(energy_rd, 0, 0))
            |=> (acc_val[0][0] == $past(acc_val[0][0]) + 32'h00000001);
    endproperty
    a_act_accum: assert property (p_act_accum) else $error("active energy missed a quantum");

    // every read is answered one cycle later
    property p_rd_answer;
        @(posedge clk) disable iff (!rstn)
            (rstn && energy_rd.valid) |=> energy_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

    // read data is the content before any clear
    property p_read_data;
        @(posedge clk) disable iff (!rstn)
            (rstn && energy_rd.valid && energy_rd.phase == 2'h0 && energy_rd.kind == noload_pkg::KIND_ACT)
            |=> (energy_rd_data == $past(acc_val[0][0]));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not the old content");

    // sticky flag stays until written
    property p_flag_holds;
        @(posedge clk) disable iff (!rstn)
            (app_flag && !status_w1c[2]) |=> app_flag;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("apparent flag dropped by itself");

    // a masked flag never pulls the line low
    property p_irq_masked;
        @(posedge clk) disable iff (!rstn)
            !first_interrupt_mask[2] |-> irq_n;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt low while masked");

    // phase field moves only on a crossing
    property p_bits_quiet;
        @(posedge clk) disable iff (!rstn)
            (rstn && !(|app_trans)) |=> $stable(phase_noload_register[8:6]);
    endproperty
    a_bits_quiet: assert property (p_bits_quiet) else $error("phase field moved without crossing");

    // a zero threshold leaves that check expired
    property p_zero_expired;
        @(posedge clk) disable iff (!rstn)
            (active_noload_threshold == 16'h0000) |-> (&act_idle);
    endproperty
    a_zero_expired: assert property (p_zero_expired) else $error("zero threshold not expired");
endmodule : energy_no_load_detect

// >>> verification/host_model.sv
// host controller model: thresholds, control bits, energy reads and interrupt service
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    input wire logic irq_n,
    input wire logic [noload_pkg::PH_W-1:0] ph,
    input wire logic rd_valid,
    input wire logic [noload_pkg::ENERGY_W-1:0] rd_data,
    output logic [noload_pkg::THRESH_W-1:0] act_th,
    output logic [noload_pkg::THRESH_W-1:0] app_th,
    output logic [noload_pkg::THRESH_W-1:0] rea_th,
    output logic [2:0] sel,
    output logic [7:0] mask,
    output logic [7:0] lcyc,
    output logic [2:0] w1c,
    output noload_pkg::energy_rd_s rd_req
);
    logic service = 1'b0; // interrupt servicing enabled
    logic busy = 1'b0; // inside the service routine
    logic [2:0] seen = 3'b000; // apparent phase bits seen last time

    // only the apparent check decides; the other two expire at once
    initial begin
        act_th = 16'h0000;
        rea_th = 16'h0000;
        app_th = 16'h0003;
        sel = 3'b111;
        mask = 8'h00;
        lcyc = 8'h00;
        w1c = 3'b000;
        rd_req = '0;
    end

    // control bits change just after an edge
    task automatic cfg(input logic [7:0] m, input logic [7:0] l, input logic [2:0] s);
        @(posedge clk);
        mask <= m;
        lcyc <= l;
        sel <= s;
    endtask : cfg

    // one read; a missing answer ends the run
    task automatic rd(input logic [1:0] p, input noload_pkg::kind_e k, output logic [31:0] d);
        int i;
        @(posedge clk);
        rd_req <= '{valid: 1'b1, phase: p, kind: k};
        @(posedge clk);
        rd_req <= '0;
        #1;
        for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (rd_valid !== 1'b1) begin
            $display("unexpected at %0t: read got no answer", $time);
            testbench.n_fail++;
            testbench.conclude();
        end
        d = rd_data;
    endtask : rd

    // write one onto the apparent flag
    task automatic clr();
        @(posedge clk);
        w1c <= 3'b100;
        @(posedge clk);
        w1c <= 3'b000;
        #1;
    endtask : clr

    // arm servicing from the phase bits as they stand now
    task automatic start();
        seen = ph[8:6];
        service = 1'b1;
    endtask : start

    // find the phase that crossed, steer its pulse term, clear, flush on exit
    task automatic serve();
        logic [8:0] now;
        logic [2:0] chg;
        logic [31:0] d;
        busy = 1'b1;
        repeat (2) @(posedge clk);
        // sample the registered bits once they have settled
        #1;
        now = ph;
        chg = now[8:6] ^ seen;
        seen = now[8:6];
        sel <= (sel & ~chg) | (chg & ~now[2:0]);
        clr();
        if ((chg & ~now[2:0]) != 3'b000) begin
            lcyc <= 8'h40;
            for (int p = 0; p < 3; p++) begin
                for (int k = 0; k < 4; k++) begin
                    rd(2'(p), noload_pkg::kind_e'(k), d);
                end
            end
            lcyc <= 8'h00;
        end
        busy = 1'b0;
    endtask : serve

    // a low interrupt line is serviced once servicing is on
    initial forever begin
        @(posedge clk);
        #1;
        if (service && irq_n === 1'b0) begin
            serve();
        end
    end
endmodule : host_model

// >>> verification/testbench.sv
// self-checking bench for the no-load detection block
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] cyc = 2'h0; // apparent feed cadence
    logic [2:0] app_on = 3'b111; // phases fed with apparent quanta
    noload_pkg::energy_evt_s [2:0] energy_evt = '0;
    noload_pkg::energy_evt_s [2:0] shot = '0; // one-off quanta from tests
    logic [15:0] act_th, app_th, rea_th;
    logic [2:0] sel, w1c, first_status_register;
    logic [7:0] mask, lcyc, die_version;
    noload_pkg::energy_rd_s rd_req;
    logic [31:0] energy_rd_data, d;
    logic energy_rd_valid, irq_n;
    logic [8:0] phase_noload_register;
    logic [3:0] energy_pulse_output;
    int n_fail = 0;
    int tests_run = 0;

    energy_no_load_detect i_energy_no_load_detect (
        .clk(clk), .rstn(rstn), .energy_evt(energy_evt), .active_noload_threshold(act_th),
        .apparent_noload_threshold(app_th), .reactive_noload_threshold(rea_th), .phase_term_select(sel),
        .first_interrupt_mask(mask), .line_cycle_mode_register(lcyc), .status_w1c(w1c), .energy_rd(rd_req),
        .energy_rd_data(energy_rd_data), .energy_rd_valid(energy_rd_valid),
        .first_status_register(first_status_register), .phase_noload_register(phase_noload_register),
        .energy_pulse_output(energy_pulse_output), .die_version(die_version), .irq_n(irq_n));

    host_model i_host_model (
        .clk(clk), .irq_n(irq_n), .ph(phase_noload_register), .rd_valid(energy_rd_valid),
        .rd_data(energy_rd_data), .act_th(act_th), .app_th(app_th), .rea_th(rea_th), .sel(sel),
        .mask(mask), .lcyc(lcyc), .w1c(w1c), .rd_req(rd_req));

    always #25 clk = ~clk;

    // apparent quanta every fourth cycle keep a phase out of total no-load
    always @(posedge clk) begin
        cyc <= cyc + 2'h1;
        for (int p = 0; p < 3; p++) begin
            energy_evt[p] <= shot[p] | {2'b00, app_on[p] & (cyc == 2'h0), 1'b0};
        end
    end

    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    // one quantum; returns in the cycle its pulse output stands
    task automatic shoot(input int p, input noload_pkg::energy_evt_s e);
        @(posedge clk);
        shot[p] <= e;
        @(posedge clk);
        shot[p] <= '0;
        @(posedge clk);
        #1;
    endtask : shoot

    // bounded wait for apparent phase bits, flag level and an idle host
    task automatic wait_for(input logic [2:0] bits, input logic flag);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (phase_noload_register[8:6] === bits && first_status_register[2] === flag
                && i_host_model.busy === 1'b0) break;
        end
        if (i == 400) begin
            $display("unexpected at %0t: wait ran out", $time);
            n_fail++;
            conclude();
        end
    endtask : wait_for

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk(first_status_register[1:0], 2'h2);
        chk(phase_noload_register[5:0], 6'h38);
        chk(die_version, noload_pkg::DIE_VERSION);
        chk(irq_n, 1'b1);
        // read-reset on: empty, count three, then empty again
        i_host_model.cfg(8'h00, 8'h40, 3'b111);
        i_host_model.rd(2'h0, noload_pkg::KIND_ACT, d);
        for (int n = 0; n < 3; n++) begin
            shoot(0, 4'h1);
            chk(energy_pulse_output[0], 1'b1);
        end
        i_host_model.rd(2'h0, noload_pkg::KIND_ACT, d);
        chk(d, 32'h3);
        i_host_model.rd(2'h0, noload_pkg::KIND_ACT, d);
        chk(d, 32'h0);
        // read-reset off keeps the count
        i_host_model.cfg(8'h00, 8'h00, 3'b111);
        shoot(0, 4'h1);
        for (int n = 0; n < 2; n++) begin
            i_host_model.rd(2'h0, noload_pkg::KIND_ACT, d);
            chk(d, 32'h1);
        end
        // fundamental checks expire at once, so fundamental energy is held off
        shoot(0, 4'h4);
        chk(energy_pulse_output[2], 1'b0);
        i_host_model.rd(2'h0, noload_pkg::KIND_FACT, d);
        chk(d, 32'h0);
        // phase 0 dropped from the pulse outputs
        i_host_model.cfg(8'h00, 8'h40, 3'b110);
        shoot(0, 4'h1);
        chk(energy_pulse_output[0], 1'b0);
        // no phase selected: no pulse of any kind
        i_host_model.cfg(8'h00, 8'h40, 3'b000);
        shoot(0, 4'h1);
        chk(energy_pulse_output, 4'h0);
        // phase 1 starves of apparent energy while the interrupt is masked
        i_host_model.cfg(8'h00, 8'h40, 3'b111);
        app_on[1] <= 1'b0;
        wait_for(3'b010, 1'b1);
        chk(irq_n, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk(first_status_register[0], 1'b1);
        chk(phase_noload_register[2:0], 3'b010);
        shoot(1, 4'h1);
        chk(energy_pulse_output[0], 1'b0);
        i_host_model.rd(2'h1, noload_pkg::KIND_ACT, d);
        chk(d, 32'h0);
        i_host_model.cfg(8'h04, 8'h40, 3'b111);
        @(posedge clk);
        #1;
        chk(irq_n, 1'b0);
        i_host_model.clr();
        chk(first_status_register[2], 1'b0);
        chk(irq_n, 1'b1);
        // host services exit of phase 1, then entry of phase 2
        i_host_model.start();
        app_on[1] <= 1'b1;
        wait_for(3'b000, 1'b0);
        chk(phase_noload_register[2:0], 3'b000);
        app_on[2] <= 1'b0;
        wait_for(3'b100, 1'b0);
        chk(i_host_model.sel, 3'b011);
        chk(irq_n, 1'b1);
        conclude();
    end
endmodule : testbench
